// ===== common/hwlc_pkg.sv
// constants, codes and carrier types of the hot water and limit settings bank
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
package hwlc_pkg;
    localparam int unsigned NREG = 32;
    localparam logic [15:0] BANK_BASE = 16'h01c0;
    // reserved words 0x1cc..0x1cf hold no storage
    localparam logic [NREG-1:0] MAP_MASK = 32'hffff_0fff;
    localparam logic [15:0] RST_VAL = 16'h0000;

    localparam logic [15:0] A_HW_EN = 16'h01c0;
    localparam logic [15:0] A_HW_SRC = 16'h01c1;
    localparam logic [15:0] A_HW_PRI_HEAT = 16'h01c2;
    localparam logic [15:0] A_HW_PRI_SEQ = 16'h01c3;
    localparam logic [15:0] A_HW_PRI_MIN = 16'h01c4;
    localparam logic [15:0] A_HW_SP = 16'h01c5;
    localparam logic [15:0] A_HW_SCHED_SP = 16'h01c6;
    localparam logic [15:0] A_HW_ON_HYST = 16'h01c7;
    localparam logic [15:0] A_HW_OFF_HYST = 16'h01c8;
    localparam logic [15:0] A_HW_PGAIN = 16'h01c9;
    localparam logic [15:0] A_HW_IGAIN = 16'h01ca;
    localparam logic [15:0] A_HW_DGAIN = 16'h01cb;
    localparam logic [15:0] A_OUT_SP = 16'h01d0;
    localparam logic [15:0] A_OUT_ACT = 16'h01d1;
    localparam logic [15:0] A_FLUE_EN = 16'h01d2;
    localparam logic [15:0] A_FLUE_SP = 16'h01d3;
    localparam logic [15:0] A_FLUE_ACT = 16'h01d4;
    localparam logic [15:0] A_FLUE_DLY = 16'h01d5;
    localparam logic [15:0] A_DT_EN = 16'h01d6;
    localparam logic [15:0] A_DT_THR = 16'h01d7;
    localparam logic [15:0] A_DT_ACT = 16'h01d8;
    localparam logic [15:0] A_DT_DLY = 16'h01d9;
    localparam logic [15:0] A_HWL_EN = 16'h01da;
    localparam logic [15:0] A_HWL_SP = 16'h01db;
    localparam logic [15:0] A_HWL_ACT = 16'h01dc;
    localparam logic [15:0] A_HEAT_RAMP_EN = 16'h01dd;
    localparam logic [15:0] A_HW_RAMP_EN = 16'h01de;
    localparam logic [15:0] A_RAMP_RATE = 16'h01df;

    localparam logic [15:0] CODE_OFF = 16'h0000;
    localparam logic [15:0] CODE_ON = 16'h0001;
    localparam logic [15:0] CODE_LOCKOUT = 16'h0000;
    localparam logic [15:0] CODE_OUT_HOLD = 16'h0001;
    localparam logic [15:0] CODE_DELAY = 16'h0002;
    localparam logic [15:0] CODE_HWL_HOLD = 16'h0002;
    localparam logic [15:0] CODE_HWL_SUSPEND = 16'h0003;
    localparam logic [15:0] NOT_CONFIGURED = 16'hffff;
    localparam logic [15:0] DELAY_MAX_S = 16'h0258;
    localparam logic signed [15:0] TEMP_MIN = 16'shfe70;
    localparam logic signed [15:0] TEMP_MAX = 16'sh0514;
    localparam logic signed [15:0] DIFF_MIN = 16'sh0000;

    typedef enum logic [1:0] {
        SRC_SENSOR = 2'h0,
        SRC_SENSOR_STAT = 2'h1,
        SRC_SWITCH_INLET = 2'h2,
        SRC_SWITCH_OUTLET = 2'h3
    } hwlc_src_e;

    typedef enum logic [1:0] {
        ACT_LOCKOUT = 2'h0,
        ACT_RECYCLE_HOLD = 2'h1,
        ACT_RECYCLE_DELAY = 2'h2,
        ACT_SUSPEND_HW = 2'h3
    } hwlc_act_e;

    typedef struct packed {
        logic [15:0] addr;
        logic wr;
        logic rd;
        logic [15:0] wdata;
    } hwlc_req_s;

    typedef struct packed {
        logic hw_enable;
        hwlc_src_e hw_source;
        logic hw_over_heat;
        logic hw_over_sequencer;
        logic hw_priority_timed;
        logic [15:0] hw_priority_minutes;
        logic [15:0] hw_active_setpoint;
        logic [15:0] hw_on_hyst;
        logic [15:0] hw_off_hyst;
        logic [15:0] hw_pgain;
        logic [15:0] hw_igain;
        logic [15:0] hw_dgain;
        logic [15:0] outlet_setpoint;
        hwlc_act_e outlet_action;
        logic flue_enable;
        logic [15:0] flue_setpoint;
        hwlc_act_e flue_action;
        logic [15:0] flue_delay;
        logic diff_enable;
        logic [15:0] diff_threshold;
        hwlc_act_e diff_action;
        logic [15:0] diff_delay;
        logic diff_delay_set;
        logic hwl_enable;
        logic [15:0] hwl_setpoint;
        hwlc_act_e hwl_action;
        logic heat_ramp_enable;
        logic hw_ramp_enable;
        logic [15:0] ramp_rate;
    } hwlc_cfg_s;

    typedef struct packed {
        logic temp_range;
        logic delay_range;
        logic bad_code;
    } hwlc_fault_s;

    function automatic logic [4:0] idx(input logic [15:0] a);
        return 5'(a - BANK_BASE);
    endfunction
endpackage

// ===== logic/hwlc_bank.sv
// hot water and limit settings bank behind the serial register protocol
`timescale 1ns/1ns
module hwlc_bank (
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire hwlc_pkg::hwlc_req_s req_in,
    input wire logic schedule_switch_in,
    output logic [15:0] rdata_out,
    output logic ack_out,
    output logic hit_out,
    output hwlc_pkg::hwlc_cfg_s cfg_out,
    output hwlc_pkg::hwlc_fault_s fault_out
);
    import hwlc_pkg::*;

    // ------------------------------------------------------------------------
    // reset release and switch synchroniser
    // ------------------------------------------------------------------------
    logic rst_s1_r;
    logic rst_n_r;
    logic sw_s1_r;
    logic sw_s2_r;
    logic sw_s3_r;
    logic sched_r;
    logic sched_nxt;

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rst_s1_r <= 1'b0;
            rst_n_r <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_n_r <= rst_s1_r;
        end
    end

    // switch only counts once stages two and three agree, filtering a bounce
    assign sched_nxt = (sw_s2_r == sw_s3_r) ? sw_s3_r : sched_r;

    always_ff @(posedge clk_in or negedge rst_n_r) begin
        if (!rst_n_r) begin
            sw_s1_r <= 1'b0;
            sw_s2_r <= 1'b0;
            sw_s3_r <= 1'b0;
            sched_r <= 1'b0;
        end else begin
            sw_s1_r <= schedule_switch_in;
            sw_s2_r <= sw_s1_r;
            sw_s3_r <= sw_s2_r;
            sched_r <= sched_nxt;
        end
    end

    // ------------------------------------------------------------------------
    // decode and storage
    // ------------------------------------------------------------------------
    logic [15:0] mem_r [NREG];
    logic [15:0] rdata_r;
    logic [15:0] rdata_nxt;
    logic ack_r;
    logic in_bank;
    logic [4:0] sel;
    logic mapped;
    logic wr_hit;

    assign in_bank = (req_in.addr[15:5] == BANK_BASE[15:5]);
    assign sel = idx(req_in.addr);
    assign mapped = in_bank && MAP_MASK[sel];
    assign wr_hit = req_in.wr && mapped;
    // reserved and foreign addresses answer zero
    assign rdata_nxt = (req_in.rd && mapped) ? mem_r[sel] : 16'h0000;

    generate
        for (genvar g = 0; g < NREG; g++) begin : g_word
            if (MAP_MASK[g]) begin : g_store
                always_ff @(posedge clk_in or negedge rst_n_r) begin
                    if (!rst_n_r) begin
                        mem_r[g] <= RST_VAL;
                    end else if (wr_hit && sel == 5'(g)) begin
                        mem_r[g] <= req_in.wdata;
                    end
                end
            end else begin : g_hole
                assign mem_r[g] = 16'h0000;
            end
        end
    endgenerate

    always_ff @(posedge clk_in or negedge rst_n_r) begin
        if (!rst_n_r) begin
            rdata_r <= 16'h0000;
            ack_r <= 1'b0;
        end else begin
            rdata_r <= rdata_nxt;
            ack_r <= req_in.rd;
        end
    end

    assign rdata_out = rdata_r;
    assign ack_out = ack_r;
    assign hit_out = mapped;

    // ------------------------------------------------------------------------
    // settings presented to the control algorithms
    // ------------------------------------------------------------------------
    hwlc_cfg_s cfg;
    logic [15:0] out_act_w;
    logic [15:0] flue_act_w;
    logic [15:0] dt_act_w;
    logic [15:0] hwl_act_w;

    assign out_act_w = mem_r[idx(A_OUT_ACT)];
    assign flue_act_w = mem_r[idx(A_FLUE_ACT)];
    assign dt_act_w = mem_r[idx(A_DT_ACT)];
    assign hwl_act_w = mem_r[idx(A_HWL_ACT)];

    // decoding is combinational on stored words so a write acts next cycle
    assign cfg.hw_enable = (mem_r[idx(A_HW_EN)] == CODE_ON);
    assign cfg.hw_source = hwlc_src_e'(mem_r[idx(A_HW_SRC)][1:0]);
    assign cfg.hw_over_heat = (mem_r[idx(A_HW_PRI_HEAT)] == CODE_ON);
    assign cfg.hw_over_sequencer = (mem_r[idx(A_HW_PRI_SEQ)] == CODE_ON);
    assign cfg.hw_priority_timed = (mem_r[idx(A_HW_PRI_MIN)] != CODE_OFF);
    assign cfg.hw_priority_minutes = mem_r[idx(A_HW_PRI_MIN)];
    assign cfg.hw_active_setpoint = sched_r ? mem_r[idx(A_HW_SCHED_SP)]
                                            : mem_r[idx(A_HW_SP)];
    assign cfg.hw_on_hyst = mem_r[idx(A_HW_ON_HYST)];
    assign cfg.hw_off_hyst = mem_r[idx(A_HW_OFF_HYST)];
    assign cfg.hw_pgain = mem_r[idx(A_HW_PGAIN)];
    assign cfg.hw_igain = mem_r[idx(A_HW_IGAIN)];
    assign cfg.hw_dgain = mem_r[idx(A_HW_DGAIN)];
    assign cfg.outlet_setpoint = mem_r[idx(A_OUT_SP)];
    // any code not documented falls back to lockout, the safe side
    assign cfg.outlet_action = (out_act_w == CODE_OUT_HOLD) ? ACT_RECYCLE_HOLD
                                                            : ACT_LOCKOUT;
    assign cfg.flue_enable = (mem_r[idx(A_FLUE_EN)] == CODE_ON);
    assign cfg.flue_setpoint = mem_r[idx(A_FLUE_SP)];
    assign cfg.flue_action = (flue_act_w == CODE_DELAY) ? ACT_RECYCLE_DELAY
                                                        : ACT_LOCKOUT;
    assign cfg.flue_delay = mem_r[idx(A_FLUE_DLY)];
    assign cfg.diff_enable = (mem_r[idx(A_DT_EN)] == CODE_ON);
    assign cfg.diff_threshold = mem_r[idx(A_DT_THR)];
    assign cfg.diff_action = (dt_act_w == CODE_DELAY) ? ACT_RECYCLE_DELAY
                                                      : ACT_LOCKOUT;
    assign cfg.diff_delay = mem_r[idx(A_DT_DLY)];
    assign cfg.diff_delay_set = (mem_r[idx(A_DT_DLY)] != NOT_CONFIGURED);
    assign cfg.hwl_enable = (mem_r[idx(A_HWL_EN)] == CODE_ON);
    assign cfg.hwl_setpoint = mem_r[idx(A_HWL_SP)];
    assign cfg.hwl_action = (hwl_act_w == CODE_HWL_HOLD) ? ACT_RECYCLE_HOLD :
                            (hwl_act_w == CODE_HWL_SUSPEND) ? ACT_SUSPEND_HW :
                            ACT_LOCKOUT;
    assign cfg.heat_ramp_enable = (mem_r[idx(A_HEAT_RAMP_EN)] == CODE_ON);
    assign cfg.hw_ramp_enable = (mem_r[idx(A_HW_RAMP_EN)] == CODE_ON);
    // rate per minute; fan rpm or firing percent is the user's choice
    assign cfg.ramp_rate = mem_r[idx(A_RAMP_RATE)];

    assign cfg_out = cfg;

    // ------------------------------------------------------------------------
    // plausibility flags; values are kept as written, only flagged
    // ------------------------------------------------------------------------
    function automatic logic out_of(input logic [15:0] v, input logic signed [15:0] lo);
        return ($signed(v) < lo) || ($signed(v) > TEMP_MAX);
    endfunction

    logic temp_bad;
    logic delay_bad;
    logic code_bad;

    assign temp_bad = out_of(mem_r[idx(A_HW_SP)], TEMP_MIN)
                   || out_of(mem_r[idx(A_HW_SCHED_SP)], TEMP_MIN)
                   || out_of(mem_r[idx(A_HW_ON_HYST)], TEMP_MIN)
                   || out_of(mem_r[idx(A_HW_OFF_HYST)], TEMP_MIN)
                   || out_of(mem_r[idx(A_OUT_SP)], TEMP_MIN)
                   || out_of(mem_r[idx(A_FLUE_SP)], TEMP_MIN)
                   || out_of(mem_r[idx(A_HWL_SP)], TEMP_MIN)
                   || out_of(mem_r[idx(A_DT_THR)], DIFF_MIN);
    assign delay_bad = (mem_r[idx(A_FLUE_DLY)] > DELAY_MAX_S)
                    || (cfg.diff_delay_set
                        && mem_r[idx(A_DT_DLY)] > DELAY_MAX_S);
    assign code_bad = (out_act_w != CODE_LOCKOUT && out_act_w != CODE_OUT_HOLD)
                   || (flue_act_w != CODE_LOCKOUT && flue_act_w != CODE_DELAY)
                   || (dt_act_w != CODE_LOCKOUT && dt_act_w != CODE_DELAY)
                   || (hwl_act_w != CODE_LOCKOUT && hwl_act_w != CODE_HWL_HOLD
                       && hwl_act_w != CODE_HWL_SUSPEND)
                   || (mem_r[idx(A_HW_SRC)][15:2] != 14'h0000);

    assign fault_out.temp_range = temp_bad;
    assign fault_out.delay_range = delay_bad;
    assign fault_out.bad_code = code_bad;

    // ------------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_r);

    property p_src_follows;
        req_in.wr && req_in.addr == A_HW_SRC
        |=> cfg_out.hw_source == hwlc_src_e'($past(req_in.wdata[1:0]));
    endproperty
    a_src_follows: assert property (p_src_follows)
        else $error("demand source not updated from write");

    property p_heat_pri;
        req_in.wr && req_in.addr == A_HW_PRI_HEAT
        |=> cfg_out.hw_over_heat == ($past(req_in.wdata) == CODE_ON);
    endproperty
    a_heat_pri: assert property (p_heat_pri)
        else $error("heat priority decode wrong");

    property p_seq_pri;
        req_in.wr && req_in.addr == A_HW_PRI_SEQ
        |=> cfg_out.hw_over_sequencer == ($past(req_in.wdata) == CODE_ON);
    endproperty
    a_seq_pri: assert property (p_seq_pri)
        else $error("sequencer priority decode wrong");

    property p_pri_timed;
        req_in.wr && req_in.addr == A_HW_PRI_MIN
        |=> cfg_out.hw_priority_timed == ($past(req_in.wdata) != CODE_OFF)
            && cfg_out.hw_priority_minutes == $past(req_in.wdata);
    endproperty
    a_pri_timed: assert property (p_pri_timed)
        else $error("priority timeout flag disagrees with minutes");

    property p_sched_sel;
        sw_s2_r && sw_s3_r ##1 sched_r
        |-> cfg_out.hw_active_setpoint == mem_r[idx(A_HW_SCHED_SP)];
    endproperty
    a_sched_sel: assert property (p_sched_sel)
        else $error("schedule setpoint not applied");

    property p_temp_flag;
        req_in.wr && req_in.addr == A_HW_SP
        && ($signed(req_in.wdata) > TEMP_MAX || $signed(req_in.wdata) < TEMP_MIN)
        |=> fault_out.temp_range;
    endproperty
    a_temp_flag: assert property (p_temp_flag)
        else $error("over-range setpoint not flagged");

    property p_outlet_act;
        req_in.wr && req_in.addr == A_OUT_ACT && req_in.wdata == CODE_OUT_HOLD
        |=> cfg_out.outlet_action == ACT_RECYCLE_HOLD;
    endproperty
    a_outlet_act: assert property (p_outlet_act)
        else $error("outlet recycle not selected");

    property p_flue_act;
        req_in.wr && req_in.addr == A_FLUE_ACT
        |=> (cfg_out.flue_action == ACT_RECYCLE_DELAY) == ($past(req_in.wdata) == CODE_DELAY);
    endproperty
    a_flue_act: assert property (p_flue_act)
        else $error("flue delay action without its code");

    property p_diff_unset;
        req_in.wr && req_in.addr == A_DT_DLY && req_in.wdata == NOT_CONFIGURED
        |=> !cfg_out.diff_delay_set;
    endproperty
    a_diff_unset: assert property (p_diff_unset)
        else $error("all-ones delay seen as configured");

    property p_hwl_act;
        req_in.wr && req_in.addr == A_HWL_ACT && req_in.wdata == CODE_HWL_SUSPEND
        |=> cfg_out.hwl_action == ACT_SUSPEND_HW;
    endproperty
    a_hwl_act: assert property (p_hwl_act)
        else $error("hot water suspend not selected");

    property p_readback;
        req_in.rd && mapped && !req_in.wr |=> ack_out && rdata_out == $past(mem_r[sel]);
    endproperty
    a_readback: assert property (p_readback)
        else $error("readback differs from stored word");

    property p_reserved_zero;
        req_in.rd && !mapped |=> ack_out && rdata_out == 16'h0000;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved address read nonzero");

    property p_write_lands;
        wr_hit
        |=> mem_r[$past(sel)] == $past(req_in.wdata);
    endproperty
    a_write_lands: assert property (p_write_lands)
        else $error("mapped write not stored next cycle");

    property p_rd_acked;
        req_in.rd
        |=> ack_out;
    endproperty
    a_rd_acked: assert property (p_rd_acked)
        else $error("read not acknowledged");

    // answer stands one cycle only, so a stale word never looks live
    property p_idle_quiet;
        !req_in.rd
        |=> !ack_out && rdata_out == 16'h0000;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet)
        else $error("acknowledge or read data without a read");

    property p_sp_normal;
        !sched_r
        |-> cfg_out.hw_active_setpoint == mem_r[idx(A_HW_SP)];
    endproperty
    a_sp_normal: assert property (p_sp_normal)
        else $error("normal setpoint not applied");

    property p_outlet_lock;
        req_in.wr && req_in.addr == A_OUT_ACT && req_in.wdata != CODE_OUT_HOLD
        |=> cfg_out.outlet_action == ACT_LOCKOUT;
    endproperty
    a_outlet_lock: assert property (p_outlet_lock)
        else $error("outlet lockout not selected");

    property p_flue_en;
        req_in.wr && req_in.addr == A_FLUE_EN
        |=> cfg_out.flue_enable == ($past(req_in.wdata) == CODE_ON);
    endproperty
    a_flue_en: assert property (p_flue_en)
        else $error("flue limit enable decode wrong");

    property p_diff_en;
        req_in.wr && req_in.addr == A_DT_EN
        |=> cfg_out.diff_enable == ($past(req_in.wdata) == CODE_ON);
    endproperty
    a_diff_en: assert property (p_diff_en)
        else $error("temp difference enable decode wrong");

    property p_hwl_en;
        req_in.wr && req_in.addr == A_HWL_EN
        |=> cfg_out.hwl_enable == ($past(req_in.wdata) == CODE_ON);
    endproperty
    a_hwl_en: assert property (p_hwl_en)
        else $error("hot water limit enable decode wrong");

    property p_heat_ramp;
        req_in.wr && req_in.addr == A_HEAT_RAMP_EN
        |=> cfg_out.heat_ramp_enable == ($past(req_in.wdata) == CODE_ON);
    endproperty
    a_heat_ramp: assert property (p_heat_ramp)
        else $error("central heat ramp enable decode wrong");

    property p_hw_ramp;
        req_in.wr && req_in.addr == A_HW_RAMP_EN
        |=> cfg_out.hw_ramp_enable == ($past(req_in.wdata) == CODE_ON);
    endproperty
    a_hw_ramp: assert property (p_hw_ramp)
        else $error("hot water ramp enable decode wrong");

    property p_ramp_rate;
        req_in.wr && req_in.addr == A_RAMP_RATE
        |=> cfg_out.ramp_rate == $past(req_in.wdata);
    endproperty
    a_ramp_rate: assert property (p_ramp_rate)
        else $error("ramp rate not presented as written");
endmodule

// ===== bench/hwlc_master.sv
// protocol master model that drives the settings bank register port
`timescale 1ns/1ns
module hwlc_master (
    input wire logic clk_in,
    input wire logic ack_in,
    input wire logic hit_in,
    input wire logic [15:0] rdata_in,
    output hwlc_pkg::hwlc_req_s req_out
);
    import hwlc_pkg::*;
    int gap = 0;
    initial req_out = '{addr: 16'h0000, wr: 1'b0, rd: 1'b0, wdata: 16'h0000};
    // released lines show the inverse, so a stale word can never pass for a live one
    task automatic let_go(input hwlc_req_s r);
        req_out = '{addr: ~r.addr, wr: 1'b0, rd: 1'b0, wdata: ~r.wdata};
        @(negedge clk_in);
    endtask
    // one whole 16-bit word per request, read or write
    task automatic write_word(input logic [15:0] a, input logic [15:0] d);
        hwlc_req_s r;
        r = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
        repeat (gap) @(negedge clk_in);
        req_out = r;
        @(negedge clk_in);
        let_go(r);
    endtask
    task automatic read_word(input logic [15:0] a, output logic [15:0] d,
                             output logic ack, output logic hit);
        hwlc_req_s r;
        r = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 16'h0000};
        repeat (gap) @(negedge clk_in);
        req_out = r;
        @(negedge clk_in);
        d = rdata_in;
        ack = ack_in;
        hit = hit_in;
        let_go(r);
    endtask
endmodule

// ===== bench/tb.sv
// self-checking bench of the settings bank against a word-level model
`timescale 1ns/1ns
module tb;
    import hwlc_pkg::*;
    logic clk_in = 1'b0;
    logic arst_n_in = 1'b0;
    logic schedule_switch_in = 1'b0;
    hwlc_req_s req;
    logic [15:0] rdata;
    logic ack;
    logic hit;
    hwlc_cfg_s cfg;
    hwlc_fault_s fault;
    int bad_count = 0;
    int n_checks = 0;
    integer seed = 32'hf88d7591;
    int mem [32];
    bit sched = 0;
    int temps [7] = '{5, 6, 7, 8, 16, 19, 27};
    int tbl [44] = '{32'h0001_0000, 32'h0001_0001, 32'h0001_0002, 32'h0001_0003,
        32'h0001_0005, 32'h0002_0001, 32'h0003_0001, 32'h0003_0002, 32'h0004_001e,
        32'h0004_0000, 32'h0000_0001, 32'h0005_02bc, 32'h0006_0190, 32'h0005_fe6f,
        32'h0005_fe70, 32'h0007_0514, 32'h0008_0515, 32'h0008_0032, 32'h0011_0001,
        32'h0011_0002, 32'h0011_0000, 32'h0014_0002, 32'h0014_0001, 32'h0014_0000,
        32'h0015_0258, 32'h0015_0259, 32'h0015_0000, 32'h0018_0002, 32'h0019_ffff,
        32'h0019_0259, 32'h0019_0258, 32'h0017_ffff, 32'h0017_0514, 32'h001c_0002,
        32'h001c_0003, 32'h001c_0001, 32'h001c_0000, 32'h0012_0001, 32'h0016_0001,
        32'h001a_0001, 32'h001d_0001, 32'h001e_0001, 32'h001f_04d2, 32'h000c_beef};

    always #25 clk_in = ~clk_in;

    hwlc_bank hwlc_bank_inst (.clk_in(clk_in), .arst_n_in(arst_n_in), .req_in(req),
        .schedule_switch_in(schedule_switch_in), .rdata_out(rdata), .ack_out(ack),
        .hit_out(hit), .cfg_out(cfg), .fault_out(fault));
    hwlc_master hwlc_master_inst (.clk_in(clk_in), .ack_in(ack), .hit_in(hit),
        .rdata_in(rdata), .req_out(req));

    // ------
    // checking helpers
    // ------
    task automatic check(input string what, input logic [255:0] seen,
                         input logic [255:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    function automatic int sv(int i);
        return int'($signed(16'(mem[i])));
    endfunction

    task automatic check_all();
        hwlc_cfg_s e;
        bit tr;
        bit dr;
        bit bc;
        e.hw_enable = mem[0] == 1;
        e.hw_source = hwlc_src_e'(mem[1][1:0]);
        e.hw_over_heat = mem[2] == 1;
        e.hw_over_sequencer = mem[3] == 1;
        e.hw_priority_timed = mem[4] != 0;
        e.hw_priority_minutes = 16'(mem[4]);
        e.hw_active_setpoint = 16'(mem[sched ? 6 : 5]);
        e.hw_on_hyst = 16'(mem[7]);
        e.hw_off_hyst = 16'(mem[8]);
        e.hw_pgain = 16'(mem[9]);
        e.hw_igain = 16'(mem[10]);
        e.hw_dgain = 16'(mem[11]);
        e.outlet_setpoint = 16'(mem[16]);
        e.outlet_action = mem[17] == 1 ? ACT_RECYCLE_HOLD : ACT_LOCKOUT;
        e.flue_enable = mem[18] == 1;
        e.flue_setpoint = 16'(mem[19]);
        e.flue_action = mem[20] == 2 ? ACT_RECYCLE_DELAY : ACT_LOCKOUT;
        e.flue_delay = 16'(mem[21]);
        e.diff_enable = mem[22] == 1;
        e.diff_threshold = 16'(mem[23]);
        e.diff_action = mem[24] == 2 ? ACT_RECYCLE_DELAY : ACT_LOCKOUT;
        e.diff_delay = 16'(mem[25]);
        e.diff_delay_set = mem[25] != 65535;
        e.hwl_enable = mem[26] == 1;
        e.hwl_setpoint = 16'(mem[27]);
        e.hwl_action = mem[28] == 2 ? ACT_RECYCLE_HOLD :
            mem[28] == 3 ? ACT_SUSPEND_HW : ACT_LOCKOUT;
        e.heat_ramp_enable = mem[29] == 1;
        e.hw_ramp_enable = mem[30] == 1;
        e.ramp_rate = 16'(mem[31]);
        tr = sv(23) < 0 || sv(23) > 1300;
        foreach (temps[k]) tr = tr || sv(temps[k]) < -400 || sv(temps[k]) > 1300;
        dr = mem[21] > 600 || (mem[25] > 600 && mem[25] != 65535);
        bc = mem[1] > 3 || mem[17] > 1 || !(mem[20] inside {0, 2}) ||
            !(mem[24] inside {0, 2}) || mem[28] == 1 || mem[28] > 3;
        check("cfg_out", 256'(cfg), 256'(e));
        check("cfg_out", 256'(cfg), 256'(e));
        check("fault_out", 256'(fault), 256'({tr, dr, bc}));
    endtask

    task automatic wr_chk(int i, logic [15:0] v);
        hwlc_master_inst.write_word(16'(BANK_BASE + i), v);
        if (!(i >= 12 && i <= 15)) mem[i] = v;
        check_all();
    endtask

    // reserved words and addresses past the bank hold nothing and read zero
    task automatic read_all();
        logic [15:0] d;
        logic a;
        logic h;
        bit m;
        for (int i = 0; i < 34; i++) begin
            hwlc_master_inst.gap = $random(seed) & 3;
            m = i < 32 && !(i >= 12 && i <= 15);
            hwlc_master_inst.read_word(16'(BANK_BASE + i), d, a, h);
            check("ack_out", 256'(a), 256'(1'b1));
            check("hit_out", 256'(h), 256'(m));
            check("rdata_out", 256'(d), 256'(m ? mem[i] : 0));
        end
    endtask

    // ------
    // main sequence
    // ------
    initial begin
        foreach (mem[i]) mem[i] = 0;
        repeat (8) @(negedge clk_in);
        arst_n_in = 1'b1;
        repeat (4) @(negedge clk_in);
        check_all();
        read_all();
        foreach (tbl[k]) wr_chk(tbl[k][31:16], tbl[k][15:0]);
        schedule_switch_in = 1'b1;
        repeat (5) @(negedge clk_in);
        sched = 1;
        check_all();
        schedule_switch_in = 1'b0;
        repeat (5) @(negedge clk_in);
        sched = 0;
        check_all();
        for (int k = 0; k < 32; k++) begin
            hwlc_master_inst.gap = $random(seed) & 3;
            wr_chk(k, 16'($random(seed)));
        end
        read_all();
        // a second reset in mid-run must clear every stored word
        arst_n_in = 1'b0;
        foreach (mem[i]) mem[i] = 0;
        repeat (2) @(negedge clk_in);
        check_all();
        arst_n_in = 1'b1;
        repeat (4) @(negedge clk_in);
        read_all();
        print_verdict();
    end

    initial begin
        #(50 * 5000);
        bad_count++;
        print_verdict();
    end
endmodule
